//--- logic/hpd_pkg.sv
// Package for the demand defrost initiation block: timing, temperature limits.
// Assumes a 40 MHz pclk; temperatures arrive as signed whole degrees F.
package hpd_pkg;
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned TICK_MS         = 1000;
    localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
    // Durations in seconds
    localparam int unsigned FORCE_RUN_S     = 6 * 3600;
    localparam int unsigned DEF_MAX_S       = 15 * 60;
    localparam int unsigned TEST_MIN_S      = 30;
    localparam int unsigned CYCLE_DLY_S     = 2 * 60;
    localparam int unsigned LOCKOUT_MAX_S   = 120 * 60;
    // Temperature limits, degrees F
    localparam logic signed [9:0] COOL_LIM_F  = 10'sd65;
    localparam logic signed [9:0] LOCK_LIM_F  = 10'sd39;
    localparam logic signed [9:0] TERM_LIM_F  = 10'sd70;
    // Threshold: 0.30*(amb-15)+1 in tenths = 3*amb - 45 + 10
    localparam logic signed [11:0] THR_OFS    = 12'sh023;
    // Ambient degrees F at the cold end and the top of the lockout table
    localparam logic signed [9:0] LOCK_AMB_LO = 10'sd19;
    localparam logic signed [9:0] LOCK_AMB_HI = 10'sd34;
    // Register map
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STAT   = 12'h004;
    localparam logic [11:0] OFS_IRQ_ST = 12'h008;
    localparam logic [11:0] OFS_IRQ_MK = 12'h00C;
    localparam logic [11:0] OFS_RUN    = 12'h010;
    localparam logic [3:0]  IRQ_RST    = 4'h0;
    typedef enum logic [1:0] {HPD_IDLE, HPD_DEF} hpd_state_t;
endpackage : hpd_pkg

//--- logic/hpd_defrost.sv
// Demand defrost initiation and termination controller with APB registers.
// Assumes synchronous, debounced inputs and temperatures already digitized.
`timescale 1ns/10ps
// How it works
// [R01] With the liquid line above 65 F the control stays off and starts no defrost.
// [R02] The threshold is 0.30*(ambient-15)+1, floored at zero below ambient 12.
// [R03] Defrost starts when ambient minus liquid exceeds the threshold.
// [R04] Below 65 F timing resumes and six hours of run time force a defrost.
// [R05] A defrost begun after cooling mode was seen since the last defrost turns the outdoor fan off and aux heat on.
// [R06] The defrost indicator is lit throughout a defrost while no self-test failure is present.
// [R07] The relay output closes at defrost start and opens at its end.
// [R08] Run time and lockout freeze while first-stage demand is low and resume from held values; the cycle delay timer clears.
// [R09] A test pin short starts a defrost lasting at least 30 seconds.
// [R10] A second short ends a test defrost, otherwise normal termination applies.
// [R11] A self-test failure disables the test pins and keeps the indicator dark.
// [R12] Each defrost ends after 15 minutes or once the coil reaches 70 F, a test defrost not before 30 seconds.
// [R13] Run time and lockout are cleared at relay closure; timing restarts after.
// [R14] Lockout and ambient monitoring begin after two minutes and below 39 F.
// [R15] Temperatures are digitized degrees F; durations come from a prescaler.
module hpd_defrost
    import hpd_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = hpd_pkg::TICK_CYC
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Sensors and unit inputs
    input  wire logic signed [9:0] liquid_temp,
    input  wire logic signed [9:0] ambient_temp,
    input  wire logic signed [9:0] coil_temp,
    input  wire logic              demand_hold_input,
    input  wire logic              test_short,
    input  wire logic              selftest_fail,
    // Outputs
    output logic                   defrost_relay_out,
    output logic                   defrost_led,
    output logic                   outdoor_fan_off,
    output logic                   aux_heat_on,
    output logic                   irq
);
    import hpd_pkg::*;

    // Lockout minutes from ambient, cold end of the table
    function automatic logic [7:0] lock_min(input logic signed [9:0] amb);
        logic [7:0] t [0:15];
        t = '{8'h78, 8'h62, 8'h55, 8'h4A, 8'h43, 8'h3D, 8'h38, 8'h34,
              8'h31, 8'h2F, 8'h2D, 8'h2C, 8'h2B, 8'h2A, 8'h29, 8'h28};
        if (amb <= LOCK_AMB_LO)
            lock_min = t[0];
        else if (amb >= LOCK_AMB_HI)
            lock_min = t[15];
        else
            lock_min = t[4'(amb - LOCK_AMB_LO)];
    endfunction : lock_min

    hpd_state_t         st_q, st_d;
    logic [31:0]        pre_q, pre_d;
    logic [15:0]        run_q, run_d;
    logic [15:0]        cyc_q, cyc_d;
    logic [15:0]        lock_q, lock_d;
    logic [15:0]        dt_q, dt_d;
    logic               test_q, test_d;
    logic               tprev_q, tprev_d;
    logic               cool_q, cool_d;
    logic               cmode_q, cmode_d;
    logic [3:0]         ist_q, ist_d;
    logic [3:0]         imk_q, imk_d;
    logic [31:0]        rdata_q, rdata_d;
    logic [3:0]         irq_ev;
    logic [3:0]         irq_clr;
    logic               tick;
    logic               tedge;
    logic               cooling;
    logic               thr_hit;
    logic               lock_ok;
    logic               force_run;
    logic               term;
    logic               start;
    logic               go;
    logic               def_end;
    logic signed [11:0] thr10, act10;

    assign tick    = (pre_q == TICK_CYCLES - 1); // R15
    assign tedge   = test_short & ~tprev_q & ~selftest_fail; // R11
    assign cooling = (liquid_temp > COOL_LIM_F); // R01
    // Threshold in tenths of a degree, clipped at zero
    always_comb begin
        thr10 = 12'(3 * 12'(signed'(ambient_temp))) - THR_OFS; // R02
        if (thr10 < 0)
            thr10 = '0; // R02
        act10 = 12'(10 * (12'(signed'(liquid_temp)) - 12'(signed'(ambient_temp))));
    end
    // Heat pump liquid runs colder than ambient; difference taken as ambient minus liquid
    assign thr_hit   = (-act10 > thr10); // R03
    assign lock_ok   = (cyc_q >= 16'(CYCLE_DLY_S)) && (liquid_temp < LOCK_LIM_F)
                       && (lock_q >= 16'(lock_min(ambient_temp) * 60)); // R14
    assign force_run = (run_q >= 16'(FORCE_RUN_S)); // R04
    assign start = !cooling && demand_hold_input && ((lock_ok && thr_hit) || force_run); // R01 R03
    assign term  = (dt_q >= 16'(DEF_MAX_S)) || (coil_temp >= TERM_LIM_F); // R12
    // No defrost of any kind starts while the liquid line is warm
    assign go    = (tedge && !cooling) || start; // R01 R09
    // Test defrost honours its minimum before either way out
    assign def_end = (st_q == HPD_DEF)
                     && ((test_q && tedge && dt_q >= 16'(TEST_MIN_S)) // R10
                         || (term && (!test_q || dt_q >= 16'(TEST_MIN_S)))); // R09 R12

    // Seconds prescaler and test pin history
    always_comb begin
        pre_d   = tick ? '0 : pre_q + 32'h1; // R15
        tprev_d = test_short;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q   <= '0;
            tprev_q <= 1'b0;
        end else begin
            pre_q   <= pre_d;
            tprev_q <= tprev_d;
        end
    end

    // Cooling mode seen, held until the next defrost ends
    always_comb begin
        cmode_d = cmode_q;
        if (cooling)
            cmode_d = 1'b1; // R05
        else if (def_end)
            cmode_d = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmode_q <= 1'b0;
        end else begin
            cmode_q <= cmode_d;
        end
    end

    // Defrost state and run timers
    always_comb begin
        st_d   = st_q;
        run_d  = run_q;
        cyc_d  = cyc_q;
        lock_d = lock_q;
        dt_d   = dt_q;
        test_d = test_q;
        cool_d = cool_q;
        case (st_q)
            HPD_IDLE: begin
                if (!demand_hold_input) begin
                    cyc_d = '0; // R08
                end else if (tick && !cooling) begin
                    run_d = run_q + 16'h1; // R08
                    cyc_d = (cyc_q == 16'hFFFF) ? cyc_q : cyc_q + 16'h1;
                    if (cyc_q >= 16'(CYCLE_DLY_S) && liquid_temp < LOCK_LIM_F
                        && lock_q < 16'(LOCKOUT_MAX_S))
                        lock_d = lock_q + 16'h1; // R14
                end
                if (go) begin
                    st_d   = HPD_DEF;
                    dt_d   = '0;
                    test_d = tedge; // R09
                    cool_d = cmode_q; // R05
                    run_d  = '0; // R13
                    lock_d = '0; // R13
                    cyc_d  = '0; // R13
                end
            end
            HPD_DEF: begin
                if (tick)
                    dt_d = dt_q + 16'h1; // R12
                if (def_end) begin
                    st_d   = HPD_IDLE; // R10 R12
                    test_d = 1'b0;
                    cool_d = 1'b0;
                end
            end
            default: st_d = HPD_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= HPD_IDLE;
            run_q  <= '0;
            cyc_q  <= '0;
            lock_q <= '0;
            dt_q   <= '0;
            test_q <= 1'b0;
            cool_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            run_q  <= run_d;
            cyc_q  <= cyc_d;
            lock_q <= lock_d;
            dt_q   <= dt_d;
            test_q <= test_d;
            cool_q <= cool_d;
        end
    end

    // Sticky events: start, end, self-test failure, cooling seen
    assign irq_ev  = {cooling, selftest_fail, def_end, (st_q == HPD_IDLE) && go};
    assign irq_clr = (psel && penable && pwrite && paddr == OFS_IRQ_ST) ? pwdata[3:0] : 4'h0;

    always_comb begin
        ist_d = (ist_q & ~irq_clr) | irq_ev; // Set wins over clear
        imk_d = imk_q;
        if (psel && penable && pwrite) begin
            if (paddr == OFS_IRQ_MK || paddr == OFS_CTRL)
                imk_d = pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_q <= IRQ_RST;
            imk_q <= IRQ_RST;
        end else begin
            ist_q <= ist_d;
            imk_q <= imk_d;
        end
    end

    // Read data latched in the setup cycle
    always_comb begin
        rdata_d = rdata_q;
        if (psel && !penable && !pwrite) begin
            if (paddr == OFS_CTRL)
                rdata_d = {28'h0, imk_q};
            else if (paddr == OFS_STAT)
                rdata_d = {26'h0, selftest_fail, cooling, cool_q, test_q, st_q == HPD_DEF,
                           defrost_relay_out};
            else if (paddr == OFS_IRQ_ST)
                rdata_d = {28'h0, ist_q};
            else if (paddr == OFS_IRQ_MK)
                rdata_d = {28'h0, imk_q};
            else if (paddr == OFS_RUN)
                rdata_d = {lock_q, run_q};
            else
                rdata_d = 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign defrost_relay_out = (st_q == HPD_DEF); // R07
    assign defrost_led       = (st_q == HPD_DEF) && !selftest_fail; // R06 R11
    assign outdoor_fan_off   = (st_q == HPD_DEF) && cool_q; // R05
    assign aux_heat_on       = (st_q == HPD_DEF) && cool_q; // R05
    assign irq     = |(ist_q & imk_q);
    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    AST_COOL_NO_START: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == HPD_IDLE && cooling && !tedge) |=> st_q == HPD_IDLE) // R01
        else $error("defrost began while cooling");
    AST_RELAY_LED: assert property (@(posedge pclk) disable iff (!presetn)
        (!selftest_fail) |-> (defrost_led == defrost_relay_out)) // R06
        else $error("indicator disagrees with relay");
    AST_CLEAR_RUN: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(defrost_relay_out) |-> run_q == 0 && lock_q == 0) // R13
        else $error("timers not cleared at relay closure");
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (!demand_hold_input && st_q == HPD_IDLE && !tedge) |=> $stable(run_q)) // R08
        else $error("run time moved without demand");
    AST_TEST_MIN: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(defrost_relay_out) && $past(test_q)) |-> $past(dt_q) >= 16'(TEST_MIN_S)) // R09
        else $error("test defrost too short");
    AST_MAX_DEF: assert property (@(posedge pclk) disable iff (!presetn)
        dt_q <= 16'(DEF_MAX_S) + 16'h1) // R12
        else $error("defrost overran");
    AST_DARK: assert property (@(posedge pclk) disable iff (!presetn)
        selftest_fail |-> !defrost_led) // R11
        else $error("indicator lit on failure");
    AST_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
        (force_run && !cooling && demand_hold_input && st_q == HPD_IDLE)
        |=> defrost_relay_out) // R04
        else $error("six hour defrost missed");
    AST_FAN: assert property (@(posedge pclk) disable iff (!presetn)
        outdoor_fan_off |-> defrost_relay_out && aux_heat_on) // R05
        else $error("fan off outside cooling defrost");
    AST_TEST_END: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == HPD_DEF && test_q && tedge && dt_q >= 16'(TEST_MIN_S)) |=> !defrost_relay_out) // R10
        else $error("second short ignored");
    AST_THR: assert property (@(posedge pclk) disable iff (!presetn)
        thr10 >= 0) // R02
        else $error("negative threshold");
    AST_IRQ_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_ev != 4'h0) |=> ((ist_q & $past(irq_ev)) == $past(irq_ev)))
        else $error("status event lost to a clear");
    AST_COIL_END: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == HPD_DEF && !test_q && coil_temp >= TERM_LIM_F) |=> !defrost_relay_out) // R12
        else $error("defrost kept past coil limit");
    AST_LOCK_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == HPD_IDLE && !go && (cyc_q < 16'(CYCLE_DLY_S) || liquid_temp >= LOCK_LIM_F))
        |=> $stable(lock_q)) // R14
        else $error("lockout counted too early");
    AST_TEST_START: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == HPD_IDLE && tedge && !cooling) |=> (defrost_relay_out && test_q)) // R09
        else $error("test short did not start defrost");
    COV_TEST_END: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == HPD_DEF && test_q && tedge && dt_q >= 16'(TEST_MIN_S));
    COV_COIL: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == HPD_DEF && coil_temp >= TERM_LIM_F);
    COV_DEMAND: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == HPD_IDLE && start && !force_run);
    COV_TEST: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == HPD_IDLE && tedge);
    COV_COOL: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(outdoor_fan_off));
endmodule : hpd_defrost

//--- sim/hpd_defrost_tb.sv
// Bench for the demand defrost block: APB registers, test pins, demand defrost.
// Assumes the block answers APB with no wait states and a 4-cycle seconds tick.
`timescale 1ns/10ps
module hpd_defrost_tb;
    import hpd_pkg::*;
    localparam int unsigned TK = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic signed [9:0] liquid_temp, ambient_temp, coil_temp;
    logic demand_hold_input, test_short, selftest_fail;
    logic defrost_relay_out, defrost_led, outdoor_fan_off, aux_heat_on, irq;
    int failures = 0;
    int n_checks = 0;
    hpd_defrost #(.TICK_CYCLES(TK)) u_hpd_defrost (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .liquid_temp(liquid_temp),
        .ambient_temp(ambient_temp), .coil_temp(coil_temp),
        .demand_hold_input(demand_hold_input), .test_short(test_short),
        .selftest_fail(selftest_fail), .defrost_relay_out(defrost_relay_out),
        .defrost_led(defrost_led), .outdoor_fan_off(outdoor_fan_off),
        .aux_heat_on(aux_heat_on), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task wrap_up;
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        chk("pslverr", 32'h0, pslverr);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
        if (i == 50) begin failures++; wrap_up(); end
    endtask : apb
    task wait_relay(input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge pclk);
            if (defrost_relay_out === v) break;
        end
        if (i == lim) begin failures++; wrap_up(); end
    endtask : wait_relay
    task pins;
        test_short <= 1'b1;
        repeat (2) @(posedge pclk);
        test_short <= 1'b0;
        @(posedge pclk);
    endtask : pins
    task sc_regs;
        chk("relay", 1'b0, defrost_relay_out);
        apb(1'b0, OFS_STAT, '0);
        chk("status", 32'h0000_0000, rd);
        apb(1'b1, OFS_IRQ_MK, 32'h0000_0003);
        apb(1'b0, OFS_IRQ_MK, '0);
        chk("mask", 32'h0000_0003, rd);
        apb(1'b0, 12'hFFC, '0);
        chk("unmapped", 32'h0000_0000, rd);
    endtask : sc_regs
    task sc_fail;
        selftest_fail <= 1'b1;
        pins();
        repeat (20) @(posedge pclk);
        chk("relay", 1'b0, defrost_relay_out);
        chk("led", 1'b0, defrost_led);
        selftest_fail <= 1'b0;
        @(posedge pclk);
    endtask : sc_fail
    task sc_test;
        pins();
        wait_relay(1'b1, 10);
        @(posedge pclk);
        chk("led", 1'b1, defrost_led);
        chk("irq", 1'b1, irq);
        apb(1'b1, OFS_IRQ_ST, 32'h0000_000F);
        @(posedge pclk);
        chk("irq", 1'b0, irq);
        apb(1'b0, OFS_STAT, '0);
        chk("status", 32'h0000_0007, rd);
        pins();
        repeat (20) @(posedge pclk);
        chk("relay", 1'b1, defrost_relay_out);
        repeat (30 * TK) @(posedge pclk);
        chk("led", 1'b1, defrost_led);
        pins();
        wait_relay(1'b0, 10);
        chk("led", 1'b0, defrost_led);
    endtask : sc_test
    task sc_cool;
        liquid_temp <= 10'sd70;
        repeat (150 * TK) @(posedge pclk);
        chk("relay", 1'b0, defrost_relay_out);
        liquid_temp <= 10'sd60;
        repeat (4) @(posedge pclk);
        pins();
        wait_relay(1'b1, 10);
        @(posedge pclk);
        chk("fan off", 1'b1, outdoor_fan_off);
        chk("aux heat", 1'b1, aux_heat_on);
        apb(1'b0, OFS_STAT, '0);
        chk("status", 32'h0000_000F, rd);
        repeat (31 * TK) @(posedge pclk);
        pins();
        wait_relay(1'b0, 10);
    endtask : sc_cool
    task sc_demand;
        liquid_temp <= 10'sd20;
        wait_relay(1'b1, 20000);
        repeat (2) @(posedge pclk);
        apb(1'b0, OFS_RUN, '0);
        chk("run time", 32'h0000_0000, rd);
        coil_temp <= 10'sd75;
        wait_relay(1'b0, 10);
        chk("led", 1'b0, defrost_led);
    endtask : sc_demand
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; liquid_temp = 10'sd30; ambient_temp = 10'sd30;
        coil_temp = 10'sd30; demand_hold_input = 1'b1; test_short = 1'b0;
        selftest_fail = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        sc_regs();
        sc_fail();
        sc_test();
        sc_cool();
        sc_demand();
        wrap_up();
    end
endmodule : hpd_defrost_tb
